/* becs_top.sv */
`default_nettype none

// Overview of operation
// R1: Bit 0 sets when the error output fires for an address parity error.
// R2: Bit 1 sets when it fires for a posted write data parity error.
// R3: Bit 2 sets when it fires for posted write data left undelivered.
// R4: Bit 3 sets when it fires for a target abort on posted write data.
// R5: Bit 4 sets when it fires for a master abort on posted write data.
// R6: Bit 5 sets when it fires for delayed write data left undelivered.
// R7: Bit 6 sets when it fires because no delayed read data was obtained.
// R8: Bit 7 sets when it fires because an initiator never repeated in time.
// R9: Status bits stick until a one is written to them and reset to zero.
// R10: A maskable event fires only if its disable bit is 0 and enable is 1.

module becs_top (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // APB slave
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [becs_pkg::BECS_AW-1:0] paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    input  wire logic [3:0]                   pstrb_i,
    output logic [31:0]                       prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    // Fault events from the bridge core, one-cycle pulses
    input  wire logic [becs_pkg::BECS_NEV-1:0] evt_i,
    // System error and interrupt outputs
    output logic                              sys_err_o,
    output logic                              irq_o
);
    import becs_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic word_hit(input logic [BECS_AW-1:0] a,
                                      input logic [BECS_AW-1:0] w);
        word_hit = (a[BECS_AW-1:2] == w[BECS_AW-1:2]);
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic     setup;
    logic     access;
    logic     wr;
    logic     hit_stat;
    logic     hit_dis;
    logic     hit_ctrl;
    logic     hit_mask;
    logic     mapped;
    logic     lane0;
    becs_ev_t wbyte;

    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign hit_stat = word_hit(paddr_i, BECS_STAT_ADDR);
    assign hit_dis  = word_hit(paddr_i, BECS_DIS_ADDR);
    assign hit_ctrl = word_hit(paddr_i, BECS_CTRL_ADDR);
    assign hit_mask = word_hit(paddr_i, BECS_MASK_ADDR);
    assign mapped   = hit_stat | hit_dis | hit_ctrl | hit_mask;
    assign lane0    = pstrb_i[0];
    assign wr       = access & pwrite_i & mapped & lane0;
    assign wbyte    = pwdata_i[7:0];

    // The slave never waits; unmapped words answer with an error.
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    becs_ev_t dis_q;
    becs_ev_t dis_d;
    becs_ev_t mask_q;
    becs_ev_t mask_d;
    logic     en_q;
    logic     en_d;

    assign dis_d  = (wr & hit_dis) ? (wbyte & BECS_MASKABLE) : dis_q;
    assign mask_d = (wr & hit_mask) ? wbyte : mask_q;
    assign en_d   = (wr & hit_ctrl) ? wbyte[BECS_CTRL_EN_BIT] : en_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dis_q  <= BECS_DIS_RST;
            mask_q <= BECS_MASK_RST;
            en_q   <= BECS_EN_RST;
        end
        else
        begin
            dis_q  <= dis_d;
            mask_q <= mask_d;
            en_q   <= en_d;
        end
    end

    // ------------------------------------------------------------------
    // Error gating and cause capture
    // ------------------------------------------------------------------
    becs_ev_t fire;
    becs_ev_t blocked;
    logic     sys_err_q;
    logic     sys_err_d;

    // Only maskable events see their disable bit; all need the enable.
    assign blocked   = dis_q & BECS_MASKABLE; // [R10]
    assign fire      = evt_i & ~blocked & {BECS_NEV{en_q}}; // [R10]
    assign sys_err_d = |fire;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sys_err_q <= 1'b0;
        end
        else
        begin
            sys_err_q <= sys_err_d;
        end
    end

    assign sys_err_o = sys_err_q;

    becs_st_if st ();

    // Each cause bit is set in the same edge that raises the error output.
    assign st.set[BECS_EV_ADDR_PAR] = fire[BECS_EV_ADDR_PAR]; // [R1]
    assign st.set[BECS_EV_PW_PAR]   = fire[BECS_EV_PW_PAR]; // [R2]
    assign st.set[BECS_EV_PW_NDLV]  = fire[BECS_EV_PW_NDLV]; // [R3]
    assign st.set[BECS_EV_PW_TABT]  = fire[BECS_EV_PW_TABT]; // [R4]
    assign st.set[BECS_EV_PW_MABT]  = fire[BECS_EV_PW_MABT]; // [R5]
    assign st.set[BECS_EV_DW_NDLV]  = fire[BECS_EV_DW_NDLV]; // [R6]
    assign st.set[BECS_EV_DR_NODAT] = fire[BECS_EV_DR_NODAT]; // [R7]
    assign st.set[BECS_EV_DT_TOUT]  = fire[BECS_EV_DT_TOUT]; // [R8]
    assign st.clr = (wr & hit_stat) ? wbyte : '0; // [R9]

    becs_sticky u_sticky (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .st    (st)
    );

    assign irq_o = |(st.stat & mask_q);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    becs_ev_t    rd_sel;

    assign rd_sel = hit_stat ? st.stat :
                    hit_dis  ? dis_q   :
                    hit_mask ? mask_q  :
                    hit_ctrl ? {7'h00, en_q} : '0;
    // Data is captured in the setup cycle and stands through the access.
    assign rd_d   = setup ? {24'h000000, rd_sel} : rd_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_q <= BECS_RD_ZERO;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end

    assign prdata_o = rd_q;

endmodule

`default_nettype wire

/* becs_pkg.sv */
`default_nettype none

package becs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Printed register indices; each index names one 32-bit word.
    localparam logic [7:0]  BECS_STAT_IDX  = 8'h6A;
    localparam logic [7:0]  BECS_DIS_IDX   = 8'h64;
    localparam int unsigned BECS_AW        = 12;
    // Byte addresses on the bus are four times the index.
    localparam logic [11:0] BECS_STAT_ADDR = {2'h0, BECS_STAT_IDX, 2'h0};
    localparam logic [11:0] BECS_DIS_ADDR  = {2'h0, BECS_DIS_IDX, 2'h0};
    localparam logic [11:0] BECS_CTRL_ADDR = 12'h1B0;
    localparam logic [11:0] BECS_MASK_ADDR = 12'h1B4;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned BECS_NEV         = 8;
    localparam int unsigned BECS_EV_ADDR_PAR = 0;
    localparam int unsigned BECS_EV_PW_PAR   = 1;
    localparam int unsigned BECS_EV_PW_NDLV  = 2;
    localparam int unsigned BECS_EV_PW_TABT  = 3;
    localparam int unsigned BECS_EV_PW_MABT  = 4;
    localparam int unsigned BECS_EV_DW_NDLV  = 5;
    localparam int unsigned BECS_EV_DR_NODAT = 6;
    localparam int unsigned BECS_EV_DT_TOUT  = 7;
    // Events that own a disable bit; bits 0 and 7 have none.
    localparam logic [7:0]  BECS_MASKABLE    = 8'h7E;
    localparam int unsigned BECS_CTRL_EN_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  BECS_STAT_RST = 8'h00;
    localparam logic [7:0]  BECS_DIS_RST  = 8'h00;
    localparam logic [7:0]  BECS_MASK_RST = 8'h00;
    localparam logic        BECS_EN_RST   = 1'b0;
    localparam logic [31:0] BECS_RD_ZERO  = 32'h00000000;

    typedef logic [BECS_NEV-1:0] becs_ev_t;

endpackage

`default_nettype wire

/* becs_st_if.sv */
`default_nettype none

// Carries set and clear requests to the sticky status bank and its state.
interface becs_st_if;
    import becs_pkg::*;

    becs_ev_t set;
    becs_ev_t clr;
    becs_ev_t stat;

    modport owner (
        input  set,
        input  clr,
        output stat
    );

    modport user (
        output set,
        output clr,
        input  stat
    );

endinterface

`default_nettype wire

/* becs_sticky.sv */
`default_nettype none

module becs_sticky (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Status bank
    becs_st_if.owner      st
);
    import becs_pkg::*;

    becs_ev_t stat_q;
    becs_ev_t stat_d;

    // A set arriving with its own clear wins, so no event is lost.
    assign stat_d  = (stat_q & ~st.clr) | st.set; // [R9]
    assign st.stat = stat_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_q <= BECS_STAT_RST; // [R9]
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

endmodule

`default_nettype wire

/* becs_top_properties.sv */
`default_nettype none
module becs_top_properties (
    input wire logic                          clk_i,
    input wire logic                          rst_i,
    input wire logic                          psel_i,
    input wire logic                          penable_i,
    input wire logic                          pwrite_i,
    input wire logic [becs_pkg::BECS_AW-1:0]  paddr_i,
    input wire logic [31:0]                   prdata_o,
    input wire logic                          pready_o,
    input wire logic                          pslverr_o,
    input wire logic [becs_pkg::BECS_NEV-1:0] evt_i,
    input wire logic                          sys_err_o,
    input wire logic                          irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import becs_pkg::*;
    logic               map_w;
    logic               acc_w;
    logic               wacc_w;
    logic [BECS_AW-1:0] wadr_w;
    // The slave decodes whole words, so the low address bits are ignored.
    assign wadr_w = {paddr_i[BECS_AW-1:2], 2'h0};
    assign map_w  = wadr_w inside {BECS_STAT_ADDR, BECS_DIS_ADDR,
                                   BECS_CTRL_ADDR, BECS_MASK_ADDR};
    assign acc_w  = psel_i && penable_i;
    assign wacc_w = acc_w && pwrite_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ready_high: assert property
        (pready_o)
        else $error("pready low");
    chk_slverr_map: assert property
        (acc_w |-> pslverr_o == !map_w)
        else $error("pslverr wrong");
    chk_rd_unmapped: assert property
        (acc_w && !map_w |-> prdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    chk_rd_upper: assert property
        (prdata_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_rd_hold: assert property
        ($changed(prdata_o) |-> $past(psel_i) && !$past(penable_i))
        else $error("read data moved outside setup");
    chk_err_cause: assert property
        (sys_err_o |-> $past(evt_i) != 8'h00)
        else $error("error output without event");
    chk_irq_rise: assert property
        ($rose(irq_o) |-> sys_err_o || $past(wacc_w))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property
        ($fell(irq_o) |-> $past(wacc_w))
        else $error("status lost without write");
endmodule
bind becs_top becs_top_properties chk (.clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .evt_i,
    .sys_err_o, .irq_o);
`default_nettype wire

/* becs_tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import becs_pkg::*;
    logic               clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
    logic               pwrite_i = 0, pready_o, pslverr_o, sys_err_o;
    logic               irq_o, er;
    logic [BECS_AW-1:0] paddr_i = '0;
    logic [31:0]        pwdata_i = '0, prdata_o, rd;
    logic [3:0]         pstrb_i = 4'hF;
    logic [7:0]         evt_i = 8'h00;
    int                 failures = 0, cmp_count = 0, cyc = 0;
    becs_top dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .evt_i,
        .sys_err_o, .irq_o);
    initial forever #10 clk_i = ~clk_i;
    task report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            report_and_stop;
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Setup, then access held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task fire(input logic [7:0] m, input logic e);
        @(posedge clk_i);
        evt_i <= m;
        @(posedge clk_i);
        evt_i <= 8'h00;
        #1 chk("sys_err", 32'(e), 32'(sys_err_o));
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(BECS_STAT_ADDR, 32'h0, "stat_rst");
        rdc(BECS_DIS_ADDR, 32'h0, "dis_rst");
        rdc(BECS_MASK_ADDR, 32'h0, "mask_rst");
        rdc(BECS_CTRL_ADDR, 32'h0, "ctrl_rst");
        $display("test reset done");
        apb(1'b1, BECS_CTRL_ADDR, 32'h1);
        apb(1'b1, BECS_MASK_ADDR, 32'hFF);
        for (int n = 0; n < 8; n++)
        begin
            fire(8'h01 << n, 1'b1);
            rdc(BECS_STAT_ADDR, 32'h1 << n, "stat_set");
            chk("irq", 32'h1, 32'(irq_o));
            apb(1'b1, BECS_STAT_ADDR, 32'h0);
            rdc(BECS_STAT_ADDR, 32'h1 << n, "stat_hold");
            apb(1'b1, BECS_STAT_ADDR, 32'h1 << n);
            rdc(BECS_STAT_ADDR, 32'h0, "stat_clr");
        end
        $display("test causes done");
        apb(1'b1, BECS_DIS_ADDR, 32'hFF);
        rdc(BECS_DIS_ADDR, 32'h7E, "dis_rw");
        fire(8'hFF, 1'b1);
        rdc(BECS_STAT_ADDR, 32'h81, "stat_dis");
        apb(1'b1, BECS_STAT_ADDR, 32'hFF);
        apb(1'b1, BECS_DIS_ADDR, 32'h0);
        apb(1'b1, BECS_CTRL_ADDR, 32'h0);
        fire(8'hFF, 1'b0);
        rdc(BECS_STAT_ADDR, 32'h0, "stat_off");
        $display("test gating done");
        apb(1'b1, BECS_CTRL_ADDR, 32'h1);
        apb(1'b1, BECS_MASK_ADDR, 32'h0);
        fire(8'h01, 1'b1);
        chk("irq_masked", 32'h0, 32'(irq_o));
        @(posedge clk_i);
        pstrb_i <= 4'h0;
        apb(1'b1, BECS_STAT_ADDR, 32'hFF);
        pstrb_i <= 4'hF;
        rdc(BECS_STAT_ADDR, 32'h1, "stat_strobe");
        apb(1'b1, BECS_MASK_ADDR, 32'h1);
        #1 chk("irq_unmask", 32'h1, 32'(irq_o));
        apb(1'b1, BECS_STAT_ADDR, 32'h1);
        #1 chk("irq_clr", 32'h0, 32'(irq_o));
        $display("test mask done");
        fire(8'h02, 1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(BECS_STAT_ADDR, 32'h0, "stat_rerst");
        rdc(BECS_CTRL_ADDR, 32'h0, "ctrl_rerst");
        $display("test second reset done");
        rdc(12'h004, 32'h0, "rd_unmapped");
        chk("slverr", 32'h1, 32'(er));
        $display("test unmapped done");
        report_and_stop;
    end
endmodule
`default_nettype wire
